// ### common/dfi_pkg.sv
// Constants, layouts and types shared by the four-line interrupt unit.
// Assumes one clock, ref_clk, whose every edge is one internal state.
package dfi_pkg;

	localparam int NUM_LINES = 4;
	localparam int ADDR_W = 14;
	localparam int DATA_W = 16;
	localparam int REG_AW = 4;

	// Register offsets on the plain register port
	localparam logic [REG_AW-1:0] OFS_MASK = 4'h0;
	localparam logic [REG_AW-1:0] OFS_CTRL = 4'h4;
	localparam logic [REG_AW-1:0] OFS_PEND = 4'h8;
	localparam logic [REG_AW-1:0] OFS_STAT = 4'hc;

	// Field positions in the interrupt control register
	localparam int CTRL_EDGE_LSB = 0;
	localparam int CTRL_NEST_BIT = 4;
	localparam int CTRL_W = 5;

	// Field positions in the status register
	localparam int STAT_HALT_BIT = 0;
	localparam int STAT_BLOCK_BIT = 1;
	localparam int STAT_BUSY_BIT = 2;

	// Reset values
	localparam logic [NUM_LINES-1:0] MASK_RESET = 4'h0;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
	localparam logic [ADDR_W-1:0] START_ADDR = 14'h0004;
	localparam logic [ADDR_W-1:0] VECTOR_BASE = 14'h0000;

	// Edges after reset release before leaving state four
	localparam logic [1:0] RELEASE_EDGES = 2'h2;

	localparam int STACK_DEPTH = 4;
	localparam int STACK_PW = 2;

	// Internal states of one instruction cycle, one-hot
	typedef enum logic [7:0] {
		ST1 = 8'h01,
		ST2 = 8'h02,
		ST3 = 8'h04,
		ST4 = 8'h08,
		ST5 = 8'h10,
		ST6 = 8'h20,
		ST7 = 8'h40,
		ST8 = 8'h80
	} dfi_state_t;

	// Interrupt service sequence, one-hot
	typedef enum logic [2:0] {
		SVC_IDLE = 3'h1,
		SVC_SKIP = 3'h2,
		SVC_VEC = 3'h4
	} dfi_svc_t;

	// Register port request
	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic wr;
		logic rd;
	} dfi_bus_req_t;

	// Execution conditions reported by the rest of the core
	typedef struct packed {
		logic halt_in;
		logic trap;
		logic bus_granted;
		logic dm_wait;
		logic pm_miss_first;
	} dfi_core_t;

endpackage : dfi_pkg

// ### logic/dfi_pc_stack.sv
// Program counter stack for interrupt return addresses.
// Assumes the caller never pushes when full nor pops when empty.
`timescale 1ns/1ps
`default_nettype none

module dfi_pc_stack
	import dfi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic push,
	input wire logic pop,
	input wire logic [ADDR_W-1:0] push_addr,
	output logic [ADDR_W-1:0] top_addr
);

	logic [ADDR_W-1:0] entry [STACK_DEPTH];
	logic [STACK_PW-1:0] ptr;
	logic [STACK_PW-1:0] top_idx;

	assign top_idx = ptr - 2'h1;
	assign top_addr = entry[top_idx];

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			ptr <= '0;
		end else if (push) begin
			ptr <= ptr + 2'h1;
		end else if (pop) begin
			ptr <= top_idx;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < STACK_DEPTH; gi++) begin : g_entry
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					entry[gi] <= '0;
				end else if (push && ptr == STACK_PW'(gi)) begin
					entry[gi] <= push_addr;
				end
			end
		end
	endgenerate

endmodule : dfi_pc_stack

`default_nettype wire

// ### logic/dfi_int_unit.sv
// Four-line interrupt request unit with state sequencer and fetch address.
// Assumes request lines and core conditions are synchronous to ref_clk,
// and that one ref_clk cycle is one internal state.
`timescale 1ns/1ps
`default_nettype none

module dfi_int_unit
	import dfi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [NUM_LINES-1:0] request_lines,
	input wire dfi_core_t core_ctl,
	input wire logic return_from_interrupt,
	input wire dfi_bus_req_t bus_req,
	output logic [DATA_W-1:0] rd_data,
	output logic [ADDR_W-1:0] program_address_bus,
	output logic program_fetch_active,
	output logic instruction_rate_clock_out,
	output logic execute_nop,
	output logic vector_taken,
	output logic [1:0] serviced_line,
	output logic halted
);

	////////////////////////////////////////////////////////////////////////
	// Helpers

	// Index of the highest set bit
	function automatic logic [1:0] top_line(input logic [NUM_LINES-1:0] v);
		logic [1:0] idx;
		idx = 2'h0;
		for (int i = 0; i < NUM_LINES; i++) begin
			if (v[i]) begin
				idx = i[1:0];
			end
		end
		return idx;
	endfunction : top_line

	// One-hot mask of a line index
	function automatic logic [NUM_LINES-1:0] line_bit(input logic [1:0] idx);
		logic [NUM_LINES-1:0] v;
		v = '0;
		v[idx] = 1'b1;
		return v;
	endfunction : line_bit

	////////////////////////////////////////////////////////////////////////
	// Declarations

	dfi_state_t state;
	dfi_state_t next_state;
	dfi_svc_t svc;
	dfi_svc_t next_svc;
	logic [1:0] rel_cnt;
	logic started;
	logic [NUM_LINES-1:0] req_sync;
	logic [NUM_LINES-1:0] req_now;
	logic [NUM_LINES-1:0] edge_latch;
	logic [NUM_LINES-1:0] interrupt_enable_bits;
	logic [CTRL_W-1:0] interrupt_control_reg;
	logic halt_latch;
	logic nest_block;
	logic rti_pend;
	logic [1:0] take_line;
	logic [ADDR_W-1:0] next_pc;

	////////////////////////////////////////////////////////////////////////
	// Internal state sequence

	wire at_st3 = (state == ST3);
	wire at_st7 = (state == ST7);
	wire at_st8 = (state == ST8);
	wire rel_done = (rel_cnt == RELEASE_EDGES - 2'h1);

	always_comb begin
		case (state)
			ST1: next_state = ST2;
			ST2: next_state = ST3;
			ST3: next_state = ST4;
			ST4: next_state = started ? ST5 : ST4;
			ST5: next_state = ST6;
			ST6: next_state = ST7;
			ST7: next_state = ST8;
			ST8: next_state = ST1;
			default: next_state = ST4;
		endcase
	end

	// Reset parks in state four; leave it on the second edge after release
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rel_cnt <= 2'h0;
			started <= 1'b0;
		end else if (!started) begin
			rel_cnt <= rel_cnt + 2'h1;
			started <= rel_done;
		end
	end

	// Runs state machine through eight states per cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST4;
		end else begin
			state <= (!started && rel_done) ? ST5 : next_state;
		end
	end

	// Clock out high in states five to eight, low in reset
	wire next_clk_out = (next_state == ST5) || (next_state == ST6) ||
		(next_state == ST7) || (next_state == ST8);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			instruction_rate_clock_out <= 1'b0;
		end else begin
			instruction_rate_clock_out <= (!started && rel_done) || (started && next_clk_out);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Request sampling and edge detection

	// Sample taken in this state seven, active high
	wire [NUM_LINES-1:0] sample_act = ~req_sync;
	wire [NUM_LINES-1:0] edge_mode = interrupt_control_reg[CTRL_EDGE_LSB +: NUM_LINES];
	wire [NUM_LINES-1:0] edge_seen = sample_act & ~req_now & edge_mode;

	// Synchronisation stage ahead of sampling
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			req_sync <= '1;
			req_now <= '0;
		end else begin
			req_sync <= request_lines;
			if (at_st7) begin
				req_now <= sample_act;
			end
		end
	end

	// Pending as seen at the end of state seven
	wire [NUM_LINES-1:0] level_pend = sample_act & ~edge_mode;
	wire [NUM_LINES-1:0] pend_now = level_pend | ((edge_latch | edge_seen) & edge_mode);
	wire [NUM_LINES-1:0] valid = pend_now & interrupt_enable_bits;
	wire [1:0] best_line = top_line(valid);

	////////////////////////////////////////////////////////////////////////
	// Service conditions

	wire stop_cond = halt_latch || core_ctl.trap || core_ctl.bus_granted || core_ctl.dm_wait;
	wire run_edge = at_st8 && !stop_cond;
	wire can_take = at_st7 && !stop_cond && !core_ctl.pm_miss_first && !nest_block;
	wire take = can_take && (|valid) && (svc == SVC_IDLE);
	wire [NUM_LINES-1:0] clr_bits = take ? line_bit(best_line) : '0;
	// A take consumes the older latched edge if there is one, otherwise the new edge that triggered it
	wire [NUM_LINES-1:0] set_bits = at_st7 ? (edge_seen & ~(clr_bits & ~edge_latch)) : '0;

	// Edge latches: a separate new edge wins over the service clear
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			edge_latch <= '0;
		end else begin
			edge_latch <= (edge_latch & ~clr_bits) | set_bits;
		end
	end

	// Halt request looked at in state three
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			halt_latch <= 1'b0;
		end else if (at_st3) begin
			halt_latch <= core_ctl.halt_in;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			take_line <= 2'h0;
		end else if (take) begin
			take_line <= best_line;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Service sequence and fetch address

	always_comb begin
		case (svc)
			SVC_IDLE: next_svc = take ? SVC_SKIP : SVC_IDLE;
			SVC_SKIP: next_svc = run_edge ? SVC_VEC : SVC_SKIP;
			SVC_VEC: next_svc = run_edge ? SVC_IDLE : SVC_VEC;
			default: next_svc = SVC_IDLE;
		endcase
	end

	wire vec_load = (svc == SVC_VEC) && run_edge;
	wire rti_load = rti_pend && run_edge && !vec_load;
	wire [ADDR_W-1:0] stack_top;
	wire [ADDR_W-1:0] vec_addr = VECTOR_BASE + {{(ADDR_W-2){1'b0}}, take_line};

	always_comb begin
		if (vec_load) begin
			next_pc = vec_addr;
		end else if (rti_load) begin
			next_pc = stack_top;
		end else begin
			next_pc = program_address_bus + 14'h0001;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			svc <= SVC_IDLE;
			program_address_bus <= START_ADDR;
		end else begin
			svc <= next_svc;
			if (run_edge) begin
				program_address_bus <= next_pc;
			end
		end
	end

	// Nop replaces the discarded fetch for one instruction cycle
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			execute_nop <= 1'b0;
			vector_taken <= 1'b0;
			serviced_line <= 2'h0;
		end else begin
			vector_taken <= vec_load;
			if (vec_load) begin
				execute_nop <= 1'b1;
				serviced_line <= take_line;
			end else if (run_edge) begin
				execute_nop <= 1'b0;
			end
		end
	end

	// Return request waits for the next cycle boundary
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rti_pend <= 1'b0;
		end else begin
			rti_pend <= return_from_interrupt || (rti_pend && !rti_load);
		end
	end

	// Block further service on entry unless nesting is enabled
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			nest_block <= 1'b0;
		end else if (vec_load) begin
			nest_block <= !interrupt_control_reg[CTRL_NEST_BIT];
		end else if (rti_load) begin
			nest_block <= 1'b0;
		end
	end

	// Return address is the discarded fetch slot
	dfi_pc_stack u_stack (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.push(vec_load),
		.pop(rti_load),
		.push_addr(program_address_bus),
		.top_addr(stack_top)
	);

	////////////////////////////////////////////////////////////////////////
	// Halt view and fetch strobe

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			halted <= 1'b0;
			program_fetch_active <= 1'b0;
		end else begin
			halted <= halt_latch || core_ctl.trap;
			program_fetch_active <= started && !halt_latch && !core_ctl.trap &&
				!core_ctl.bus_granted;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Register port

	wire wr_mask = bus_req.wr && (bus_req.addr == OFS_MASK);
	wire wr_ctrl = bus_req.wr && (bus_req.addr == OFS_CTRL);

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			interrupt_enable_bits <= MASK_RESET;
			interrupt_control_reg <= CTRL_RESET;
		end else begin
			if (wr_mask) begin
				interrupt_enable_bits <= bus_req.wdata[NUM_LINES-1:0];
			end
			if (wr_ctrl) begin
				interrupt_control_reg <= bus_req.wdata[CTRL_W-1:0];
			end
		end
	end

	logic [DATA_W-1:0] stat_word;
	logic [DATA_W-1:0] rd_sel;

	always_comb begin
		stat_word = '0;
		stat_word[STAT_HALT_BIT] = halted;
		stat_word[STAT_BLOCK_BIT] = nest_block;
		stat_word[STAT_BUSY_BIT] = (svc != SVC_IDLE);
	end

	always_comb begin
		case (bus_req.addr)
			OFS_MASK: rd_sel = {{(DATA_W-NUM_LINES){1'b0}}, interrupt_enable_bits};
			OFS_CTRL: rd_sel = {{(DATA_W-CTRL_W){1'b0}}, interrupt_control_reg};
			OFS_PEND: rd_sel = {{(DATA_W-NUM_LINES){1'b0}}, edge_latch | (req_now & ~edge_mode)};
			OFS_STAT: rd_sel = stat_word;
			default: rd_sel = '0;
		endcase
	end

	// Read data valid only in the cycle after the strobe
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= bus_req.rd ? rd_sel : '0;
		end
	end

endmodule : dfi_int_unit

`default_nettype wire

// ### testbench/dfi_int_unit_asserts.sv
// Port checker for the four-line interrupt unit.
// Assumes one clock, ref_clk, and asynchronous active-low rst_n.
`timescale 1ns/1ps
`default_nettype none

module dfi_int_unit_asserts
	import dfi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire dfi_bus_req_t bus_req,
	input wire logic [DATA_W-1:0] rd_data,
	input wire logic [ADDR_W-1:0] program_address_bus,
	input wire logic instruction_rate_clock_out,
	input wire logic execute_nop,
	input wire logic vector_taken,
	input wire logic [1:0] serviced_line,
	input wire logic halted
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);

	a_clk_high_four: assert property (
		$rose(instruction_rate_clock_out) |->
		instruction_rate_clock_out[*4] ##1 !instruction_rate_clock_out)
		else $error("clock out high phase wrong");
	a_clk_low_four: assert property (
		$fell(instruction_rate_clock_out) |->
		!instruction_rate_clock_out[*4] ##1 instruction_rate_clock_out)
		else $error("clock out low phase wrong");
	a_rd_idle_zero: assert property (
		!$past(bus_req.rd) |-> rd_data == '0)
		else $error("read data outside its cycle");
	a_vector_is_line: assert property (
		vector_taken |-> program_address_bus == VECTOR_BASE + ADDR_W'(serviced_line))
		else $error("vector address not line index");
	a_nop_then_vector: assert property (
		$rose(execute_nop) |-> vector_taken)
		else $error("vector pulse missing after nop");
	a_nop_one_slot: assert property (
		$rose(execute_nop) |-> execute_nop[*8] ##1 !execute_nop)
		else $error("nop slot length wrong");
	a_pc_at_st8: assert property (
		$changed(program_address_bus) |-> $fell(instruction_rate_clock_out))
		else $error("fetch address moved outside state eight end");
	a_start_addr: assert property (
		$rose(rst_n) |-> program_address_bus == START_ADDR)
		else $error("start address wrong after reset");
	a_halt_pc_hold: assert property (
		halted[*8] |-> $stable(program_address_bus))
		else $error("fetch address moved while halted");
endmodule : dfi_int_unit_asserts

bind dfi_int_unit dfi_int_unit_asserts u_asserts (
	.ref_clk(ref_clk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
	.program_address_bus(program_address_bus),
	.instruction_rate_clock_out(instruction_rate_clock_out),
	.execute_nop(execute_nop), .vector_taken(vector_taken),
	.serviced_line(serviced_line), .halted(halted)
);

`default_nettype wire

// ### testbench/dfi_periph_model.sv
// Peripheral model driving the four active-low request lines.
// Assumes bench commands change just after a rising ref_clk edge.
`timescale 1ns/1ps
`default_nettype none

module dfi_periph_model
	import dfi_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic [NUM_LINES-1:0] lvl_hold,
	input wire logic [NUM_LINES-1:0] edge_fire,
	output logic [NUM_LINES-1:0] request_lines
);
	// Edge requests stay low 12 states, past one instruction cycle
	logic [NUM_LINES-1:0][3:0] hold_cnt;

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_cnt <= '0;
		end else begin
			for (int i = 0; i < NUM_LINES; i++) begin
				if (edge_fire[i]) begin
					hold_cnt[i] <= 4'hc;
				end else if (hold_cnt[i] != 4'h0) begin
					hold_cnt[i] <= hold_cnt[i] - 4'h1;
				end
			end
		end
	end

	// Level request held until the bench drops it
	always_comb begin
		for (int i = 0; i < NUM_LINES; i++) begin
			request_lines[i] = ~(lvl_hold[i] | (hold_cnt[i] != 4'h0));
		end
	end
endmodule : dfi_periph_model

`default_nettype wire

// ### testbench/dfi_int_unit_tb.sv
// Self-checking bench for the four-line interrupt unit.
// Assumes the peripheral model and the bound checker compile first.
`timescale 1ns/1ps
`default_nettype none

module dfi_int_unit_tb
	import dfi_pkg::*;
;
	typedef struct packed {
		logic [REG_AW-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic [DATA_W-1:0] exp;
	} dfi_row_t;
	localparam dfi_row_t ROWS [6] = '{
		'{OFS_MASK, 16'hfff5, 16'h0005},
		'{OFS_CTRL, 16'hffea, 16'h000a},
		'{OFS_CTRL, 16'h001f, 16'h001f},
		'{4'h2, 16'hffff, 16'h0000},
		'{OFS_STAT, 16'hffff, 16'h0000},
		'{OFS_MASK, 16'h000f, 16'h000f}
	};
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [3:0] lvl_hold = 4'h0;
	logic [3:0] edge_fire = 4'h0;
	dfi_core_t core_ctl = '0;
	logic return_from_interrupt = 1'b0;
	dfi_bus_req_t bus_req = '0;
	wire logic [3:0] request_lines;
	logic [DATA_W-1:0] rd_data;
	logic [ADDR_W-1:0] program_address_bus;
	logic program_fetch_active;
	logic instruction_rate_clock_out;
	logic execute_nop;
	logic vector_taken;
	logic [1:0] serviced_line;
	logic halted;
	int fails = 0;
	int total_checks = 0;
	int vt_cnt = 0;
	int cycles = 0;

	dfi_int_unit dut (.ref_clk(ref_clk), .rst_n(rst_n), .request_lines(request_lines),
		.core_ctl(core_ctl), .return_from_interrupt(return_from_interrupt),
		.bus_req(bus_req), .rd_data(rd_data), .program_address_bus(program_address_bus),
		.program_fetch_active(program_fetch_active),
		.instruction_rate_clock_out(instruction_rate_clock_out), .execute_nop(execute_nop),
		.vector_taken(vector_taken), .serviced_line(serviced_line), .halted(halted));
	dfi_periph_model u_periph (.ref_clk(ref_clk), .rst_n(rst_n), .lvl_hold(lvl_hold),
		.edge_fire(edge_fire), .request_lines(request_lines));

	always #4 ref_clk = ~ref_clk;
	always @(negedge ref_clk) if (vector_taken === 1'b1) vt_cnt++;
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			fails++;
			close_out();
		end
	end

	////////////////////////////////////////////////////////////////////////
	task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		total_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD %s expected %h seen %h", name, exp, got);
		end
	endtask : chk
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk);
		bus_req.wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		@(posedge ref_clk);
		bus_req <= '{addr: a, wdata: 16'h0, wr: 1'b0, rd: 1'b1};
		@(posedge ref_clk);
		bus_req.rd <= 1'b0;
		@(negedge ref_clk);
		chk("rd_data", e, rd_data);
	endtask : rd
	task automatic fire(input logic [3:0] m);
		@(posedge ref_clk);
		edge_fire <= m;
		@(posedge ref_clk);
		edge_fire <= 4'h0;
	endtask : fire
	task automatic ret();
		@(posedge ref_clk);
		return_from_interrupt <= 1'b1;
		@(posedge ref_clk);
		return_from_interrupt <= 1'b0;
	endtask : ret
	// Waits for one vector pulse, then checks line and fetch address
	task automatic wait_vec(input logic [1:0] l);
		int n;
		n = 0;
		while (vector_taken !== 1'b1 && n < 200) begin
			@(negedge ref_clk);
			n++;
		end
		chk("vector_taken", 16'h1, 16'(vector_taken));
		chk("serviced_line", 16'(l), 16'(serviced_line));
		chk("vector_addr", 16'(l), 16'(program_address_bus));
		@(negedge ref_clk);
	endtask : wait_vec
	task automatic quiet();
		int c0;
		@(posedge ref_clk);
		c0 = vt_cnt;
		repeat (48) @(posedge ref_clk);
		chk("vector_count", 16'(c0), 16'(vt_cnt));
	endtask : quiet
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, fails);
		if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : close_out

	////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (5) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("pc_reset", 16'(START_ADDR), 16'(program_address_bus));
		chk("clk_out_reset", 16'h0, 16'(instruction_rate_clock_out));
		@(posedge ref_clk);
		rst_n <= 1'b1;
		rd(OFS_MASK, 16'(MASK_RESET));
		for (int i = 0; i < 6; i++) begin
			wr(ROWS[i].addr, ROWS[i].wdata);
			rd(ROWS[i].addr, ROWS[i].exp);
		end
		for (int i = 0; i < 4; i++) begin
			fire(4'h1 << i);
			wait_vec(i[1:0]);
			ret();
		end
		quiet();
		fire(4'ha);
		wait_vec(2'h3);
		ret();
		wait_vec(2'h1);
		ret();
		wr(OFS_MASK, 16'h0000);
		fire(4'h4);
		quiet();
		wr(OFS_MASK, 16'h000f);
		wait_vec(2'h2);
		ret();
		@(posedge ref_clk);
		core_ctl.halt_in <= 1'b1;
		while (halted !== 1'b1) @(negedge ref_clk);
		fire(4'h1);
		quiet();
		@(negedge ref_clk);
		chk("halted", 16'h1, 16'(halted));
		chk("fetch_active", 16'h0, 16'(program_fetch_active));
		rd(OFS_PEND, 16'h0001);
		rd(OFS_STAT, 16'h0001);
		@(posedge ref_clk);
		core_ctl.halt_in <= 1'b0;
		wait_vec(2'h0);
		chk("fetch_active", 16'h1, 16'(program_fetch_active));
		ret();
		wr(OFS_CTRL, 16'h0000);
		@(posedge ref_clk);
		lvl_hold <= 4'h2;
		wait_vec(2'h1);
		quiet();
		rd(OFS_STAT, 16'h0002);
		ret();
		wait_vec(2'h1);
		@(posedge ref_clk);
		lvl_hold <= 4'h0;
		ret();
		quiet();
		core_ctl.pm_miss_first <= 1'b1;
		lvl_hold <= 4'h1;
		quiet();
		core_ctl.pm_miss_first <= 1'b0;
		wait_vec(2'h0);
		@(posedge ref_clk);
		lvl_hold <= 4'h0;
		ret();
		@(posedge ref_clk);
		core_ctl.trap <= 1'b1;
		repeat (2) @(posedge ref_clk);
		@(negedge ref_clk);
		chk("halted_trap", 16'h1, 16'(halted));
		chk("fetch_trap", 16'h0, 16'(program_fetch_active));
		@(posedge ref_clk);
		core_ctl.trap <= 1'b0;
		close_out();
	end
endmodule : dfi_int_unit_tb

`default_nettype wire
